// ---- src/flmc_pkg.sv ----
/*
 * Shared constants and types for the flash LED mode controller.
 * Assumes one 200 MHz clock and a synchronous active-low reset.
 */
package flmc_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned TIMEOUT_MS      = 1000;
    localparam int unsigned TIMEOUT_CYCLES  =
        (TIMEOUT_MS * 1000 * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W           = 28;
    localparam int unsigned NUM_SINKS       = 4;
    localparam int unsigned TEMP_W          = 8;
    localparam logic [7:0]  TEMP_HI_C       = 8'h96;
    localparam logic [7:0]  TEMP_LO_C       = 8'h78;
    localparam logic        OT_RESET        = 1'b0;
    localparam logic        TMO_RESET       = 1'b0;

    typedef enum logic [2:0]
    {
        FLMC_OFF   = 3'b000,
        FLMC_START = 3'b001,
        FLMC_TORCH = 3'b010,
        FLMC_FLASH = 3'b011,
        FLMC_TMO   = 3'b100
    } flmc_state_e;

    typedef struct packed
    {
        logic                 pump_on;
        logic                 rail_connect;
        logic                 flash_level;
        logic [NUM_SINKS-1:0] sink_on;
    } flmc_drive_s;

endpackage : flmc_pkg

// ---- src/flmc_top.sv ----
/*
 * Mode controller of a switched-capacitor flash LED driver.
 * Assumes the four control pins and the temperature word are asynchronous
 * and that an analog rail monitor reports regulation as a level.
 */
`timescale 1ns/10ps
`default_nettype none
module flmc_top
    import flmc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CNT = flmc_pkg::TIMEOUT_CYCLES
)
(
    input  wire logic                   i_clk,        // 200 MHz clock
    input  wire logic                   i_rstn,       // Sync reset, low
    input  wire logic                   i_enable,     // Master enable pin
    input  wire logic                   i_flash_sel,  // Torch/flash select
    input  wire logic                   i_rf_inhibit, // RF pulse inhibit
    input  wire logic                   i_sink4_dis,  // Disable fourth sink
    input  wire logic                   i_rail_ok,    // Rail in regulation
    input  wire logic [TEMP_W-1:0]      i_temp_c,     // Junction temp, C
    output flmc_pkg::flmc_drive_s       o_drive,      // Power stage drive
    output logic                        o_timeout,    // Timeout latched
    output logic                        o_overtemp    // Thermal shutdown
);
    import flmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [3:0]        pin_s1_reg;
    logic [3:0]        pin_s2_reg;
    logic              rail_s1_reg;
    logic              rail_s2_reg;
    logic [TEMP_W-1:0] temp_s1_reg;
    logic [TEMP_W-1:0] temp_s2_reg;

    // Undriven pins resolve low in the pad pull-down, so reset is low too
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            pin_s1_reg  <= 4'h0;
            pin_s2_reg  <= 4'h0;
            rail_s1_reg <= 1'b0;
            rail_s2_reg <= 1'b0;
            temp_s1_reg <= 8'h00;
            temp_s2_reg <= 8'h00;
        end
        else
        begin
            pin_s1_reg  <= {i_sink4_dis, i_rf_inhibit, i_flash_sel, i_enable};
            pin_s2_reg  <= pin_s1_reg;
            rail_s1_reg <= i_rail_ok;
            rail_s2_reg <= rail_s1_reg;
            temp_s1_reg <= i_temp_c;
            temp_s2_reg <= temp_s1_reg;
        end
    end

    wire en_w      = pin_s2_reg[0];
    wire flash_w   = pin_s2_reg[1];
    wire inhibit_w = pin_s2_reg[2];
    wire sel4_w    = pin_s2_reg[3];
    wire rail_w    = rail_s2_reg;

    ////////////////////////////////////////////////////////////////////////
    // Over-temperature with hysteresis
    logic ot_reg;
    logic ot_next;

    wire temp_hot_w  = temp_s2_reg > TEMP_HI_C;
    wire temp_cool_w = temp_s2_reg < TEMP_LO_C;

    always_comb
    begin
        ot_next = ot_reg;
        if (temp_hot_w)
            ot_next = 1'b1;
        else if (temp_cool_w)
            ot_next = 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            ot_reg <= OT_RESET;
        else
            ot_reg <= ot_next;
    end

    wire active_w = en_w && !ot_reg;

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine
    flmc_state_e      state_reg;
    flmc_state_e      state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;

    wire flash_run_w = (state_reg == FLMC_FLASH) && !inhibit_w;
    wire tmr_hit_w   = flash_run_w && (tmr_reg >= TMR_W'(TIMEOUT_CNT - 1));

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            FLMC_OFF:
                if (active_w)
                    state_next = FLMC_START;
            FLMC_START:
                if (!active_w)
                    state_next = FLMC_OFF;
                else if (rail_w)
                    state_next = FLMC_TORCH;
            FLMC_TORCH:
                if (!active_w)
                    state_next = FLMC_OFF;
                else if (flash_w)
                    state_next = FLMC_FLASH;
            FLMC_FLASH:
                if (!active_w)
                    state_next = FLMC_OFF;
                else if (tmr_hit_w)
                    state_next = FLMC_TMO;
                else if (!flash_w)
                    state_next = FLMC_TORCH;
            FLMC_TMO:
                if (!active_w)
                    state_next = FLMC_OFF;
            default:
                state_next = FLMC_OFF;
        endcase
    end

    always_comb
    begin
        tmr_next = '0;
        if (flash_run_w && flash_w && active_w)
            tmr_next = tmr_reg + 1'b1;
        else if ((state_reg == FLMC_FLASH) && inhibit_w && flash_w && active_w)
            tmr_next = tmr_reg;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            state_reg <= FLMC_OFF;
            tmr_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg   <= tmr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power stage drive
    flmc_drive_s drive_next;
    flmc_drive_s drive_reg;
    logic        tmo_reg;

    wire pumping_w = (state_reg != FLMC_OFF);
    wire sinks_w   = (state_reg == FLMC_TORCH) ||
                     (state_reg == FLMC_FLASH);
    wire [NUM_SINKS-1:0] sink_mask_w = sel4_w ? 4'h7 : 4'hf;

    always_comb
    begin
        drive_next.pump_on      = pumping_w;
        drive_next.rail_connect = pumping_w;
        drive_next.flash_level  = flash_run_w;
        drive_next.sink_on      = sinks_w ? sink_mask_w : 4'h0;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            drive_reg <= '0;
            tmo_reg   <= TMO_RESET;
        end
        else
        begin
            drive_reg <= drive_next;
            tmo_reg   <= (state_reg == FLMC_TMO);
        end
    end

    assign o_drive    = drive_reg;
    assign o_timeout  = tmo_reg;
    assign o_overtemp = ot_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_shutdown;
        @(posedge i_clk) disable iff (!i_rstn)
        (!en_w && !$past(en_w)) |=> !o_drive.pump_on && o_drive.sink_on == 0;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("Drive active while disabled");

    property p_start_wait;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_START) |=> o_drive.pump_on && o_drive.sink_on == 0;
    endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("Sinks on before rail regulated");

    property p_torch;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_TORCH) |=> !o_drive.flash_level;
    endproperty
    a_torch: assert property (p_torch)
        else $error("Flash level in torch mode");

    property p_flash;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_FLASH && !inhibit_w) |=> o_drive.flash_level;
    endproperty
    a_flash: assert property (p_flash)
        else $error("Flash level missing");

    property p_tmo_off;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_TMO) |=> o_drive.sink_on == 0 && o_drive.pump_on;
    endproperty
    a_tmo_off: assert property (p_tmo_off)
        else $error("Timeout drive wrong");

    property p_tmo_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_TMO && active_w) |=> state_reg == FLMC_TMO;
    endproperty
    a_tmo_hold: assert property (p_tmo_hold)
        else $error("Timeout left while enabled");

    property p_inhibit;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_FLASH && inhibit_w) |=> !o_drive.flash_level;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("Flash level during inhibit");

    property p_inhibit_tmr;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_FLASH && inhibit_w) |=> state_reg != FLMC_TMO;
    endproperty
    a_inhibit_tmr: assert property (p_inhibit_tmr)
        else $error("Timeout during inhibit");

    property p_restore;
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == FLMC_FLASH && !inhibit_w && $past(inhibit_w))
            |=> o_drive.flash_level;
    endproperty
    a_restore: assert property (p_restore)
        else $error("Flash level not restored");

    property p_sink4_on;
        @(posedge i_clk) disable iff (!i_rstn)
        (!sel4_w && sinks_w) |=> o_drive.sink_on == 4'hf;
    endproperty
    a_sink4_on: assert property (p_sink4_on)
        else $error("Sink missing while all enabled");

    property p_sink4;
        @(posedge i_clk) disable iff (!i_rstn)
        sel4_w && $past(sel4_w) |=> !o_drive.sink_on[3];
    endproperty
    a_sink4: assert property (p_sink4)
        else $error("Fourth sink on while disabled");

    property p_hot;
        @(posedge i_clk) disable iff (!i_rstn)
        temp_hot_w |=> ##2 o_drive.sink_on == 0 && !o_drive.pump_on;
    endproperty
    a_hot: assert property (p_hot)
        else $error("Running while hot");

    property p_hyst;
        @(posedge i_clk) disable iff (!i_rstn)
        (ot_reg && !temp_cool_w) |=> ot_reg;
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("Thermal release too early");

    property p_tmr_clr;
        @(posedge i_clk) disable iff (!i_rstn)
        (!flash_w || !active_w) |=> tmr_reg == 0;
    endproperty
    a_tmr_clr: assert property (p_tmr_clr)
        else $error("Timer not cleared");

endmodule : flmc_top
`default_nettype wire

// ---- dv/flmc_host_model.sv ----
/*
 * Host processor and RF amplifier side of the flash LED mode controller.
 * Assumes the bench calls set_pins; pins change just after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module flmc_host_model
(
    input  wire logic i_clk,        // Block clock
    output logic      o_enable,     // Master enable
    output logic      o_flash_sel,  // Torch/flash select
    output logic      o_rf_inhibit, // RF pulse inhibit
    output logic      o_sink4_dis   // Fourth sink disable
);
    // Undriven pins rest low, as the pull-downs hold them
    initial
    begin
        {o_enable, o_flash_sel, o_rf_inhibit, o_sink4_dis} = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins as {enable, select, inhibit, disable}; enable low clears timeout
    task automatic set_pins(input logic [3:0] p);
        @(posedge i_clk);
        #1;
        {o_enable, o_flash_sel, o_rf_inhibit, o_sink4_dis} = p;
    endtask : set_pins
endmodule : flmc_host_model
`default_nettype wire

// ---- dv/tb_flash_led_mode_control.sv ----
/*
 * Self-checking bench of the flash LED mode controller.
 * Assumes a 50-cycle timeout and the host model driving the control pins.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_flash_led_mode_control;
    import flmc_pkg::*;

    logic        clk;
    logic        rstn;
    logic        en;
    logic        fs;
    logic        tx;
    logic        sel;
    logic        rail_ok;
    logic [7:0]  temp;
    flmc_drive_s drive;
    logic        tmo;
    logic        ot;
    int          n_errors;
    int          compares;

    flmc_host_model host
    (
        .i_clk        (clk),
        .o_enable     (en),
        .o_flash_sel  (fs),
        .o_rf_inhibit (tx),
        .o_sink4_dis  (sel)
    );

    flmc_top #(.TIMEOUT_CNT(50)) dut
    (
        .i_clk        (clk),
        .i_rstn       (rstn),
        .i_enable     (en),
        .i_flash_sel  (fs),
        .i_rf_inhibit (tx),
        .i_sink4_dis  (sel),
        .i_rail_ok    (rail_ok),
        .i_temp_c     (temp),
        .o_drive      (drive),
        .o_timeout    (tmo),
        .o_overtemp   (ot)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Expected word is {drive, timeout, overtemp}
    task automatic step(input logic [3:0] p, input logic r,
                        input logic [7:0] t, input int n,
                        input logic [8:0] e);
        host.set_pins(p);
        rail_ok = r;
        temp    = t;
        repeat (n) @(posedge clk);
        #1;
        chk({drive, tmo, ot}, e);
    endtask : step

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        #20000;
        n_errors++;
        test_done();
    end

    initial
    begin
        n_errors = 0;
        compares = 0;
        rstn     = 1'b0;
        rail_ok  = 1'b0;
        temp     = 8'h19;
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        chk({drive, tmo, ot}, 9'h000);
        step(4'h8, 1'b0, 8'h19, 8, 9'h180);
        step(4'h8, 1'b1, 8'h19, 8, 9'h1bc);
        step(4'h9, 1'b1, 8'h19, 8, 9'h19c);
        step(4'hd, 1'b1, 8'h19, 8, 9'h1dc);
        step(4'hc, 1'b1, 8'h19, 8, 9'h1fc);
        step(4'he, 1'b1, 8'h19, 100, 9'h1bc);
        step(4'hc, 1'b1, 8'h19, 8, 9'h1fc);
        step(4'hc, 1'b1, 8'h19, 60, 9'h182);
        step(4'h8, 1'b1, 8'h19, 8, 9'h182);
        step(4'h0, 1'b1, 8'h19, 8, 9'h000);
        step(4'h8, 1'b1, 8'h19, 8, 9'h1bc);
        step(4'hc, 1'b1, 8'h19, 30, 9'h1fc);
        step(4'h8, 1'b1, 8'h19, 8, 9'h1bc);
        step(4'hc, 1'b1, 8'h19, 30, 9'h1fc);
        step(4'hc, 1'b1, 8'h96, 8, 9'h1fc);
        step(4'hc, 1'b1, 8'h97, 8, 9'h001);
        step(4'h8, 1'b1, 8'h82, 8, 9'h001);
        step(4'h8, 1'b1, 8'h78, 8, 9'h001);
        step(4'h8, 1'b1, 8'h77, 12, 9'h1bc);
        test_done();
    end
endmodule : tb_flash_led_mode_control
`default_nettype wire
